// [shared/lss_regs.svh]
/*
  Register offsets, field positions, reset values and timing counts of the
  link startup and supervision block.
  Assumes a 12-bit APB byte address and a 100 MHz pclk.
*/
`ifndef LSS_REGS_SVH
`define LSS_REGS_SVH

`define LSS_OFF_LIMIT      12'h000
`define LSS_OFF_STATUS     12'h004
`define LSS_OFF_IRQ_STS    12'h008
`define LSS_OFF_IRQ_MASK   12'h00C

`define LSS_LIMIT_RST      16'h0000
`define LSS_LIMIT_OFF      16'h0000
`define LSS_LIMIT_NOCHECK  16'h270F
`define LSS_MASK_RST       4'h0

`define LSS_EV_TIMEOUT     0
`define LSS_EV_FRAME_ERR   1
`define LSS_EV_PWR_LOSS    2
`define LSS_EV_COAST       3

`define LSS_STAT_MODE_LSB  0
`define LSS_STAT_RUN       2
`define LSS_STAT_ALARM     3
`define LSS_STAT_LINK_OK   4
`define LSS_STAT_INTERLOCK 5
`define LSS_STAT_SEL_LSB   6

`define LSS_SEL_CLASSIC    2'h0
`define LSS_SEL_LINK       2'h1
`define LSS_SEL_RESTORE    2'h2
`define LSS_OPSEL_PANEL    2'h1

`define LSS_CLK_NS         10
`define LSS_TICK_NS        100000000
`define LSS_TICK_CYCLES    (`LSS_TICK_NS / `LSS_CLK_NS)

`endif

// [shared/lss_pkg.sv]
/*
  Types shared by the link startup and supervision block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package lss_pkg;

  typedef enum logic [1:0] {
    LSS_MODE_EXT   = 2'b00,
    LSS_MODE_PANEL = 2'b01,
    LSS_MODE_LINK  = 2'b10
  } lss_mode_t;

  typedef enum logic [1:0] {
    LSS_FSM_BOOT   = 2'b00,
    LSS_FSM_ACTIVE = 2'b01,
    LSS_FSM_PLOSS  = 2'b10
  } lss_fsm_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } lss_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } lss_apb_rsp_t;

  typedef struct packed {
    logic frame_ok;
    logic frame_err;
    logic run_cmd;
  } lss_host_rx_t;

  typedef struct packed {
    logic      drive_run;
    logic      link_timeout_alarm;
    lss_mode_t op_mode;
    logic      panel_enable;
  } lss_drive_t;

endpackage

// [rtl/lss_tick_gen.sv]
/*
  Prescaler giving one pulse every 0.1 s of pclk.
  Assumes restart is a one-cycle pulse from the supervisor.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lss_regs.svh"
module lss_tick_gen #(
  parameter int unsigned TICK_CYCLES = `LSS_TICK_CYCLES
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic restart,
  output logic      tick
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } lss_tick_state_t;

  lss_tick_state_t q, d;

  always_comb begin
    d      = q;
    d.tick = 1'b0;
    if (restart) begin
      d.cnt = 32'h0;
    end else if (q.cnt == 32'(TICK_CYCLES - 1)) begin
      d.cnt  = 32'h0;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick = q.tick;
endmodule
`default_nettype wire

// [rtl/lss_interval_timer.sv]
/*
  Host communication interval counter in 0.1 s ticks.
  Assumes limit is 1..9998 while enable is high.
*/
`timescale 1ns/1ps
`default_nettype none
module lss_interval_timer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        enable,
  input  wire logic        restart,
  input  wire logic        tick,
  input  wire logic [15:0] limit,
  output logic             expired
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        fired;
    logic        expired;
  } lss_tmr_state_t;

  lss_tmr_state_t q, d;

  always_comb begin
    d         = q;
    d.expired = 1'b0;
    if (!enable || restart) begin
      d.cnt   = 16'h0000;
      d.fired = 1'b0;
    end else if (tick && !q.fired) begin
      // one pulse per silence; re-armed by a valid frame or by enable going low
      if (q.cnt + 16'h0001 >= limit) begin
        d.fired   = 1'b1;
        d.expired = 1'b1;
      end
      d.cnt = q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign expired = q.expired;
endmodule
`default_nettype wire

// [rtl/lss_top.sv]
/*
  Startup mode selection and host-link supervision with an APB register
  file and one level interrupt.
  Assumes the serial front end flags each received frame as good or bad
  in one pulse, and that settings inputs come from the parameter store.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lss_regs.svh"
module lss_top #(
  parameter int unsigned TICK_CYCLES = `LSS_TICK_CYCLES
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire lss_pkg::lss_apb_req_t apb_req,
  output lss_pkg::lss_apb_rsp_t     apb_rsp,
  input  wire logic [1:0]           startup_mode_select,
  input  wire logic [1:0]           operating_mode_select,
  input  wire logic                 link_card_fitted,
  input  wire logic                 link_params_match,
  input  wire logic                 power_fail,
  input  wire lss_pkg::lss_host_rx_t host_rx,
  input  wire logic                 clear_input_terminal,
  input  wire logic                 contact_common,
  output logic                      reply_start,
  output lss_pkg::lss_drive_t       drive,
  output logic                      irq
);
  import lss_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    lss_fsm_t    st;
    lss_mode_t   mode;
    logic [1:0]  start_sel;
    logic        run;
    logic        run_snap;
    logic        alarm;
    logic        reply;
    logic [15:0] limit;
    logic [3:0]  sts;
    logic [3:0]  mask;
    logic [31:0] prdata;
    logic        pslverr;
  } lss_top_state_t;

  lss_top_state_t q, d;

  logic       apb_setup;
  logic       apb_write;
  logic       accept;
  logic       coast_stop;
  logic       limit_off;
  logic       check_on;
  logic       tmr_enable;
  logic       tmr_restart;
  logic       tick;
  logic       expired;
  logic [3:0] ev;
  logic [7:0] status_word;

  ////////////////////////////////////////////////////////////////////////////
  // mode choice on power-up and on power return

  function automatic lss_mode_t pick_mode(
    input logic [1:0] sel,
    input logic [1:0] opsel
  );
    lss_mode_t m;
    m = LSS_MODE_EXT;
    case (sel)
      `LSS_SEL_LINK,
      `LSS_SEL_RESTORE: begin
        // params are not checked here: mismatch still lands in link mode
        m = LSS_MODE_LINK;
      end
      default: begin
        if (opsel == `LSS_OPSEL_PANEL) begin
          m = LSS_MODE_PANEL;
        end else begin
          m = LSS_MODE_EXT;
        end
      end
    endcase
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // supervision terms

  assign limit_off = (q.limit == `LSS_LIMIT_OFF);

  // 9999 and above mean no timeout check
  assign check_on = !limit_off && (q.limit < `LSS_LIMIT_NOCHECK);

  // a frame counts only when clean, in link mode, with a matching link
  assign accept = host_rx.frame_ok && !host_rx.frame_err
               && (q.st == LSS_FSM_ACTIVE) && !power_fail
               && (q.mode == LSS_MODE_LINK)
               && link_params_match;

  assign coast_stop = clear_input_terminal && contact_common;

  assign tmr_enable = (q.st == LSS_FSM_ACTIVE)
                   && (q.mode == LSS_MODE_LINK)
                   && check_on && !q.alarm;

  assign tmr_restart = accept;

  assign apb_setup = apb_req.psel && !apb_req.penable;
  assign apb_write = apb_req.psel && apb_req.penable && apb_req.pwrite;

  assign status_word = {q.start_sel,
                        limit_off,
                        link_params_match,
                        q.alarm,
                        q.run,
                        q.mode};

  // sticky sources
  assign ev[`LSS_EV_TIMEOUT]   = expired;
  assign ev[`LSS_EV_FRAME_ERR] = host_rx.frame_err;
  assign ev[`LSS_EV_PWR_LOSS]  = (q.st == LSS_FSM_ACTIVE) && power_fail;
  assign ev[`LSS_EV_COAST]     = coast_stop && q.run;

  ////////////////////////////////////////////////////////////////////////////
  // timers

  lss_tick_gen #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .restart (tmr_restart),
    .tick    (tick)
  );

  lss_interval_timer u_tmr (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (tmr_enable),
    .restart (tmr_restart),
    .tick    (tick),
    .limit   (q.limit),
    .expired (expired)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    d       = q;
    d.reply = 1'b0;

    // read data captured in setup so that it leaves a flip-flop
    if (apb_setup) begin
      d.prdata  = 32'h0000_0000;
      d.pslverr = 1'b0;
      case (apb_req.paddr)
        `LSS_OFF_LIMIT: begin
          d.prdata = {16'h0000, q.limit};
        end
        `LSS_OFF_STATUS: begin
          d.prdata = {24'h00_0000, status_word};
        end
        `LSS_OFF_IRQ_STS: begin
          d.prdata = {28'h000_0000, q.sts};
        end
        `LSS_OFF_IRQ_MASK: begin
          d.prdata = {28'h000_0000, q.mask};
        end
        default: begin
          d.pslverr = 1'b1;
        end
      endcase
    end

    if (apb_write && !q.pslverr) begin
      case (apb_req.paddr)
        `LSS_OFF_LIMIT: begin
          d.limit = apb_req.pwdata[15:0];
        end
        `LSS_OFF_IRQ_STS: begin
          d.sts = q.sts & ~apb_req.pwdata[3:0];
        end
        `LSS_OFF_IRQ_MASK: begin
          d.mask = apb_req.pwdata[3:0];
        end
        default: begin
        end
      endcase
    end

    // set after clear: an event in the clearing cycle survives
    d.sts = d.sts | ev;

    case (q.st)
      LSS_FSM_BOOT: begin
        // one look at the setting, kept until the next power cycle
        d.start_sel = startup_mode_select;
        d.mode      = pick_mode(startup_mode_select,
                                operating_mode_select);
        d.run       = 1'b0;
        d.st        = LSS_FSM_ACTIVE;
      end

      LSS_FSM_ACTIVE: begin
        if (power_fail) begin
          // drop any reply in flight; the sequence is not resumed
          d.run_snap = q.run;
          d.run      = 1'b0;
          d.reply    = 1'b0;
          d.st       = LSS_FSM_PLOSS;
        end else begin
          if (accept) begin
            // exactly one answer, only to a clean request
            d.reply = 1'b1;
            if (!host_rx.run_cmd) begin
              d.run = 1'b0;
            end else if (!limit_off && !q.alarm) begin
              d.run = 1'b1;
            end
          end
          if (q.mode == LSS_MODE_LINK && limit_off) begin
            d.run = 1'b0;
          end
          if (expired) begin
            d.run   = 1'b0;
            d.alarm = 1'b1;
          end
        end
      end

      LSS_FSM_PLOSS: begin
        if (!power_fail) begin
          d.st   = LSS_FSM_ACTIVE;
          d.mode = pick_mode(q.start_sel, operating_mode_select);
          d.run  = 1'b0;
          if (q.start_sel == `LSS_SEL_RESTORE && link_card_fitted) begin
            // resumes without waiting for any host message
            d.run = q.run_snap && !q.alarm && !limit_off;
          end
        end
      end

      default: begin
        d.st = LSS_FSM_BOOT;
      end
    endcase

    // hard-wired stop, whatever the link is doing
    if (coast_stop) begin
      d.run      = 1'b0;
      d.run_snap = 1'b0;
      d.alarm    = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q.st        <= LSS_FSM_BOOT;
      q.mode      <= LSS_MODE_EXT;
      q.start_sel <= `LSS_SEL_CLASSIC;
      q.run       <= 1'b0;
      q.run_snap  <= 1'b0;
      q.alarm     <= 1'b0;
      q.reply     <= 1'b0;
      q.limit     <= `LSS_LIMIT_RST;
      q.sts       <= 4'h0;
      q.mask      <= `LSS_MASK_RST;
      q.prdata    <= 32'h0000_0000;
      q.pslverr   <= 1'b0;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // zero wait states: the setup cycle already loaded the answer
  assign apb_rsp.pready  = apb_req.psel && apb_req.penable;
  assign apb_rsp.prdata  = q.prdata;
  assign apb_rsp.pslverr = q.pslverr && apb_req.psel && apb_req.penable;

  assign reply_start = q.reply;

  assign drive.drive_run          = q.run;
  assign drive.link_timeout_alarm = q.alarm;
  assign drive.op_mode            = q.mode;
  // panel is dead in link mode when the link settings disagree
  assign drive.panel_enable = (q.st != LSS_FSM_BOOT)
                           && ((q.mode != LSS_MODE_LINK)
                           || link_params_match);

  assign irq = |(q.sts & q.mask);

endmodule
`default_nettype wire

// [sim/lss_props.sv]
/*
  Port-level checker for the link startup and supervision top.
  Assumes it is bound to lss_top and sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none
module lss_props (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  link_params_match,
  input wire logic                  power_fail,
  input wire lss_pkg::lss_host_rx_t host_rx,
  input wire logic                  clear_input_terminal,
  input wire logic                  contact_common,
  input wire logic                  reply_start,
  input wire lss_pkg::lss_drive_t   drive
);
  import lss_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  //////////////////////////////////////////////////
  reply_cause_a: assert property (
    reply_start |-> $past(host_rx.frame_ok && !host_rx.frame_err))
    else $error("reply without an accepted frame");
  err_discard_a: assert property (host_rx.frame_err |=> !reply_start)
    else $error("reply to an erroneous frame");
  ploss_stop_a: assert property (
    power_fail |=> !drive.drive_run && !reply_start)
    else $error("drive or reply active in power loss");
  coast_stop_a: assert property (
    clear_input_terminal && contact_common |=> !drive.drive_run && !drive.link_timeout_alarm)
    else $error("coast stop ignored");
  alarm_stop_a: assert property ($rose(drive.link_timeout_alarm) |-> !drive.drive_run)
    else $error("alarm raised with drive running");
  // restore after power return is the only other way to start
  run_cause_a: assert property (
    $rose(drive.drive_run) |-> $past(host_rx.frame_ok && !host_rx.frame_err && host_rx.run_cmd)
      || $past(power_fail) || $past(power_fail, 2) || $past(power_fail, 3))
    else $error("drive started without a run frame");
  link_panel_a: assert property (
    drive.op_mode == LSS_MODE_LINK && !link_params_match |-> !drive.panel_enable)
    else $error("panel live with mismatched link");
  mode_hold_a: assert property (
    $changed(drive.op_mode) |-> !$past(presetn) || !$past(presetn, 2)
      || $past(power_fail) || $past(power_fail, 2))
    else $error("mode changed outside boot");
endmodule

bind lss_top lss_props u_props (
  .pclk(pclk), .presetn(presetn), .link_params_match(link_params_match),
  .power_fail(power_fail), .host_rx(host_rx), .clear_input_terminal(clear_input_terminal),
  .contact_common(contact_common), .reply_start(reply_start), .drive(drive));
`default_nettype wire

// [sim/lss_host_model.sv]
/*
  Host computer model: sends one frame per call and counts the answers.
  Assumes frames are one-cycle strobes from the serial front end.
*/
`timescale 1ns/1ps
`default_nettype none
module lss_host_model (
  input  wire logic            pclk,
  input  wire logic            reply_start,
  output lss_pkg::lss_host_rx_t host_rx,
  output int                   reply_cnt
);
  import lss_pkg::*;
  initial begin
    host_rx = '0;
    reply_cnt = 0;
  end
  always @(posedge pclk) begin
    if (reply_start === 1'b1) reply_cnt <= reply_cnt + 1;
  end
  //////////////////////////////////////////////////
  // caller decides retries and polling rate
  task automatic send(input logic run, input logic err);
    @(posedge pclk);
    host_rx <= '{frame_ok: 1'b1, frame_err: err, run_cmd: run};
    @(posedge pclk);
    host_rx <= '0;
  endtask
endmodule
`default_nettype wire

// [sim/link_startup_and_supervision_tb.sv]
/*
  Testbench for lss_top: APB register access, host frames, power and coast.
  Assumes a short tick prescaler (4 cycles) and the host model beside it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lss_regs.svh"
module link_startup_and_supervision_tb;
  import lss_pkg::*;
  logic         pclk = 1'b0;
  logic         presetn, card, match, pf, clr, com, reply, irq, er;
  logic [1:0]   sm, ops;
  logic [31:0]  rd;
  lss_apb_req_t req;
  lss_apb_rsp_t rsp;
  lss_host_rx_t hrx;
  lss_drive_t   drv;
  int           error_cnt, samples_checked, n;
  always #5 pclk = ~pclk;
  lss_top #(.TICK_CYCLES(4)) u_dut (.pclk(pclk), .presetn(presetn), .apb_req(req),
    .apb_rsp(rsp), .startup_mode_select(sm), .operating_mode_select(ops),
    .link_card_fitted(card), .link_params_match(match), .power_fail(pf), .host_rx(hrx),
    .clear_input_terminal(clr), .contact_common(com), .reply_start(reply), .drive(drv),
    .irq(irq));
  lss_host_model u_host (.pclk(pclk), .reply_start(reply), .host_rx(hrx), .reply_cnt());
  //////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int k;
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge pclk);
    req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (rsp.pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      error_cnt++;
      close_out();
    end
    rd = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
  endtask
  task automatic frame(input logic run, input logic err, input int exp_rep);
    int c0;
    c0 = u_host.reply_cnt;
    u_host.send(run, err);
    repeat (2) @(posedge pclk);
    chk(u_host.reply_cnt - c0, exp_rep);
  endtask
  task automatic boot(input logic [1:0] s, input logic [1:0] o, input logic m);
    presetn <= 1'b0;
    sm <= s;
    ops <= o;
    card <= 1'b1;
    match <= m;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask
  //////////////////////////////////////////////////
  initial begin
    req = '0;
    {pf, clr, com} = 3'h0;
    error_cnt = 0;
    samples_checked = 0;
    boot(2'h1, 2'h0, 1'b1);
    chk(drv.op_mode, LSS_MODE_LINK);
    apb(1'b0, `LSS_OFF_STATUS, 32'h0);
    chk(rd[7:5], 3'h3);
    frame(1'b1, 1'b0, 1);
    chk(drv.drive_run, 1'b0);
    apb(1'b1, `LSS_OFF_LIMIT, 32'h14);
    apb(1'b0, `LSS_OFF_LIMIT, 32'h0);
    chk(rd, 32'h14);
    $display("test startup and interlock done");
    frame(1'b1, 1'b1, 0);
    chk(drv.drive_run, 1'b0);
    frame(1'b1, 1'b0, 1);
    repeat (12) begin
      repeat (18) @(posedge pclk);
      chk(drv.link_timeout_alarm, 1'b0);
      frame(1'b1, 1'b0, 1);
    end
    chk(drv.drive_run, 1'b1);
    n = 0;
    while (drv.link_timeout_alarm !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 200) begin
      error_cnt++;
      close_out();
    end
    chk(n > 74 && n < 86, 1'b1);
    chk(drv.drive_run, 1'b0);
    frame(1'b1, 1'b0, 1);
    chk(drv.drive_run, 1'b0);
    apb(1'b0, `LSS_OFF_IRQ_STS, 32'h0);
    chk(rd, 32'h3);
    apb(1'b1, `LSS_OFF_IRQ_MASK, 32'h1);
    @(posedge pclk);
    chk(irq, 1'b1);
    apb(1'b1, `LSS_OFF_IRQ_MASK, 32'h0);
    @(posedge pclk);
    chk(irq, 1'b0);
    apb(1'b1, `LSS_OFF_IRQ_STS, 32'hF);
    apb(1'b0, `LSS_OFF_IRQ_STS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    $display("test timeout done");
    clr <= 1'b1;
    com <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(drv.link_timeout_alarm, 1'b0);
    chk(drv.drive_run, 1'b0);
    {clr, com} <= 2'h0;
    $display("test coast stop done");
    boot(2'h2, 2'h0, 1'b1);
    apb(1'b1, `LSS_OFF_LIMIT, 32'h14);
    frame(1'b1, 1'b0, 1);
    pf <= 1'b1;
    frame(1'b0, 1'b0, 0);
    chk(drv.drive_run, 1'b0);
    pf <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({drv.op_mode, drv.drive_run}, {LSS_MODE_LINK, 1'b1});
    // without the card a power return must not restart the drive
    card <= 1'b0;
    pf <= 1'b1;
    repeat (2) @(posedge pclk);
    pf <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({drv.op_mode, drv.drive_run}, {LSS_MODE_LINK, 1'b0});
    $display("test power return done");
    apb(1'b1, `LSS_OFF_LIMIT, 32'h270F);
    frame(1'b1, 1'b0, 1);
    // longer than 9999 ticks of 4 cycles: a live check would have fired
    repeat (40100) @(posedge pclk);
    chk({drv.link_timeout_alarm, drv.drive_run}, 2'h1);
    clr <= 1'b1;
    com <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(drv.drive_run, 1'b0);
    {clr, com} <= 2'h0;
    apb(1'b0, `LSS_OFF_IRQ_STS, 32'h0);
    chk(rd, 32'hC);
    $display("test no check and coast events done");
    for (int i = 0; i < 3; i++) begin
      boot(2'h0, i[1:0], 1'b1);
      chk(drv.op_mode, (i == 1) ? LSS_MODE_PANEL : LSS_MODE_EXT);
    end
    boot(2'h3, 2'h1, 1'b1);
    chk(drv.op_mode, LSS_MODE_PANEL);
    boot(2'h1, 2'h1, 1'b0);
    chk({drv.op_mode, drv.panel_enable}, {LSS_MODE_LINK, 1'b0});
    frame(1'b1, 1'b0, 0);
    $display("test startup modes done");
    close_out();
  end
endmodule
`default_nettype wire
